//--- src/ipl_pkg.sv
package ipl_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int NSRC = 17;
   localparam int ADR_W = 8;
   localparam int DAT_W = 32;
   localparam int SEL_W = 4;
   localparam int REG_W = 16;
   localparam int IDX_W = 6;
   localparam int LVL_W = 2;
   localparam int VEC_W = 7;
   localparam int NREG = 3;
   localparam int BYTE_W = 8;

   // ----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_DEBUG = 6'h01;
   localparam logic [IDX_W-1:0] IDX_GRP_A = 6'h02;
   localparam logic [IDX_W-1:0] IDX_GRP_B = 6'h03;
   localparam logic [IDX_W-1:0] IDX_FAST0 = 6'h0B;
   localparam logic [IDX_W-1:0] IDX_FAST1 = 6'h0E;
   localparam logic [IDX_W-1:0] IDX_EXT_CFG = 6'h20;
   localparam logic [IDX_W-1:0] IDX_STATUS = 6'h21;

   // register slots inside the priority array
   localparam int REG_DEBUG = 0;
   localparam int REG_GRP_A = 1;
   localparam int REG_GRP_B = 2;

   // writable bits of each priority register, reserved bits stay zero
   localparam logic [REG_W-1:0] MASK_DEBUG = 16'h003F;
   localparam logic [REG_W-1:0] MASK_GRP_A = 16'hFFCF;
   localparam logic [REG_W-1:0] MASK_GRP_B = 16'hFFFC;
   localparam logic [REG_W-1:0] RST_PRIO = 16'h0000;
   localparam logic [VEC_W-1:0] RST_VEC = 7'h00;

   // ext_cfg and status bit positions
   localparam int CFG_EDGE_A = 0;
   localparam int CFG_EDGE_B = 1;
   localparam int CFG_W = 2;
   localparam int ST_PIN_A = 0;
   localparam int ST_PIN_B = 1;
   localparam int ST_LOW_PWR = 2;
   localparam int ST_WAKE = 3;

   // ----------------------------------------------------------------
   // field codes and core level encodings
   // ----------------------------------------------------------------
   localparam logic [LVL_W-1:0] CODE_OFF = 2'h0;
   localparam logic [LVL_W-1:0] LVL_ONE = 2'h1;
   localparam logic [LVL_W-1:0] LVL_TWO = 2'h2;
   localparam logic [LVL_W-1:0] LVL_THREE = 2'h3;
   localparam logic [LVL_W-1:0] IPL_NONE = 2'h0;
   localparam logic [LVL_W-1:0] IPL_P0 = 2'h1;
   localparam logic [LVL_W-1:0] IPL_P1 = 2'h2;
   localparam logic [LVL_W-1:0] IPL_P23 = 2'h3;

   // ----------------------------------------------------------------
   // source map: 0 trace, 1 tx empty, 2 rx full, 3 ext a, 4 ext b,
   // 5 low voltage, 6 pll unlock, 7 flash error, 8 flash cmd done,
   // 9 flash bufs empty, 10 can bus off, 11 can error, 12 can wakeup,
   // 13 can msgbuf, 14 port f, 15 port e, 16 port d
   // ----------------------------------------------------------------
   localparam int SRC_EXT_A = 3;
   localparam int SRC_EXT_B = 4;
   localparam int NDBG = 3;
   localparam int SRC_REG [NSRC] = '{0, 0, 0, 1, 1, 1, 1, 1, 1, 1,
                                     2, 2, 2, 2, 2, 2, 2};
   localparam int SRC_LSB [NSRC] = '{0, 2, 4, 0, 2, 6, 8, 10, 12, 14,
                                     2, 4, 6, 8, 10, 12, 14};
   // vector numbers per source, plain defaults
   localparam logic [VEC_W-1:0] SRC_VEC [NSRC] = '{7'h10, 7'h11, 7'h12,
      7'h13, 7'h14, 7'h15, 7'h16, 7'h17, 7'h18, 7'h19, 7'h1A, 7'h1B,
      7'h1C, 7'h1D, 7'h1E, 7'h1F, 7'h20};

endpackage : ipl_pkg

//--- src/ipl_level_decode.sv
`timescale 1ns/1ps
`default_nettype none
module ipl_level_decode (
   input wire logic [ipl_pkg::LVL_W-1:0] code_i,
   input wire logic debug_i,
   output logic en_o,
   output logic [ipl_pkg::LVL_W-1:0] level_o
);
   import ipl_pkg::*;

   // ----------------------------------------------------------------
   // code to enable and level
   // ----------------------------------------------------------------
   // debug fields map 01..11 to 1..3, others to 0..2
   always_comb begin
      en_o = (code_i != CODE_OFF);
      if (debug_i) begin
         level_o = code_i;
      end else begin
         level_o = code_i - LVL_ONE;
      end
   end

endmodule : ipl_level_decode
`default_nettype wire

//--- src/ipl_nest_check.sv
`timescale 1ns/1ps
`default_nettype none
module ipl_nest_check (
   input wire logic [ipl_pkg::LVL_W-1:0] core_ipl_i,
   input wire logic [ipl_pkg::LVL_W-1:0] level_i,
   output logic accept_o
);
   import ipl_pkg::*;

   // ----------------------------------------------------------------
   // nesting acceptance against core level
   // ----------------------------------------------------------------
   always_comb begin
      case (core_ipl_i)
         IPL_NONE: accept_o = 1'b1;
         IPL_P0: accept_o = (level_i >= LVL_ONE);
         IPL_P1: accept_o = (level_i >= LVL_TWO);
         IPL_P23: accept_o = (level_i == LVL_THREE);
         default: accept_o = 1'b0;
      endcase
   end

endmodule : ipl_nest_check
`default_nettype wire

//--- src/ipl_regs.sv
`timescale 1ns/1ps
`default_nettype none
module ipl_regs (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ipl_pkg::ADR_W-1:0] adr_i,
   input wire logic [ipl_pkg::SEL_W-1:0] sel_i,
   input wire logic [ipl_pkg::DAT_W-1:0] dat_i,
   output logic [ipl_pkg::DAT_W-1:0] dat_o,
   output logic ack_o,
   input wire logic [ipl_pkg::NSRC-1:0] src_req_i,
   input wire logic ext_req_a_i,
   input wire logic ext_req_b_i,
   input wire logic [ipl_pkg::LVL_W-1:0] core_ipl_i,
   input wire logic low_power_i,
   output logic [ipl_pkg::NSRC-1:0] src_en_o,
   output logic [ipl_pkg::NSRC*ipl_pkg::LVL_W-1:0] src_level_o,
   output logic [ipl_pkg::NSRC-1:0] src_req_o,
   output logic [ipl_pkg::NSRC-1:0] nest_ok_o,
   output logic [ipl_pkg::NSRC-1:0] fast_o,
   output logic wake_o
);
   import ipl_pkg::*;

   typedef enum logic {ipl_run, ipl_low} ipl_pwr_t;

   logic [REG_W-1:0] prio [NREG];
   logic [VEC_W-1:0] fast_match_0;
   logic [VEC_W-1:0] fast_match_1;
   logic [CFG_W-1:0] ext_cfg;
   logic [IDX_W-1:0] idx;
   logic wr_go;
   logic [REG_W-1:0] wr_bits;
   logic [REG_W-1:0] lane_mask;
   logic [DAT_W-1:0] next_dat;
   logic [NSRC-1:0] dec_en;
   logic [LVL_W-1:0] dec_level [NSRC];
   logic [NSRC-1:0] accept;
   logic [NSRC-1:0] raw_req;
   logic [NSRC-1:0] en_snap;
   ipl_pwr_t pwr;
   logic [2:0] sync_a;
   logic [2:0] sync_b;
   logic pin_a;
   logic pin_b;
   logic pin_a_d;
   logic pin_b_d;
   logic edge_a;
   logic edge_b;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   // register index and write strobe, taken on the ack edge
   assign idx = adr_i[IDX_W+1:2];
   assign wr_go = cyc_i && stb_i && we_i && ack_o;
   assign lane_mask = {{BYTE_W{sel_i[1]}}, {BYTE_W{sel_i[0]}}};
   assign wr_bits = dat_i[REG_W-1:0];

   // ack one cycle after the request, dropped the next cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= cyc_i && stb_i && !ack_o;
      end
   end

   // ----------------------------------------------------------------
   // priority registers
   // ----------------------------------------------------------------
   // masked byte-lane writes, reserved bits never stored
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prio[REG_DEBUG] <= RST_PRIO;
         prio[REG_GRP_A] <= RST_PRIO;
         prio[REG_GRP_B] <= RST_PRIO;
      end else if (wr_go) begin
         case (idx)
            IDX_DEBUG: prio[REG_DEBUG] <= ((prio[REG_DEBUG] & ~lane_mask)
               | (wr_bits & lane_mask)) & MASK_DEBUG;
            IDX_GRP_A: prio[REG_GRP_A] <= ((prio[REG_GRP_A] & ~lane_mask)
               | (wr_bits & lane_mask)) & MASK_GRP_A;
            IDX_GRP_B: prio[REG_GRP_B] <= ((prio[REG_GRP_B] & ~lane_mask)
               | (wr_bits & lane_mask)) & MASK_GRP_B;
            default: ;
         endcase
      end
   end

   // fast match vectors and external edge configuration
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fast_match_0 <= RST_VEC;
         fast_match_1 <= RST_VEC;
         ext_cfg <= '0;
      end else if (wr_go && sel_i[0]) begin
         case (idx)
            IDX_FAST0: fast_match_0 <= wr_bits[VEC_W-1:0];
            IDX_FAST1: fast_match_1 <= wr_bits[VEC_W-1:0];
            IDX_EXT_CFG: ext_cfg <= wr_bits[CFG_W-1:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   // unmapped indices read zero
   always_comb begin
      next_dat = '0;
      case (idx)
         IDX_DEBUG: next_dat[REG_W-1:0] = prio[REG_DEBUG];
         IDX_GRP_A: next_dat[REG_W-1:0] = prio[REG_GRP_A];
         IDX_GRP_B: next_dat[REG_W-1:0] = prio[REG_GRP_B];
         IDX_FAST0: next_dat[VEC_W-1:0] = fast_match_0;
         IDX_FAST1: next_dat[VEC_W-1:0] = fast_match_1;
         IDX_EXT_CFG: next_dat[CFG_W-1:0] = ext_cfg;
         IDX_STATUS: begin
            next_dat[ST_PIN_A] = pin_a;
            next_dat[ST_PIN_B] = pin_b;
            next_dat[ST_LOW_PWR] = (pwr == ipl_low);
            next_dat[ST_WAKE] = wake_o;
         end
         default: next_dat = '0;
      endcase
   end

   // read data registered alongside ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= '0;
      end else if (cyc_i && stb_i && !ack_o) begin
         dat_o <= next_dat;
      end
   end

   // ----------------------------------------------------------------
   // per-source decode
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NSRC; gi++) begin : g_src
         // field extraction and level decoding
         ipl_level_decode u_dec (
            .code_i(prio[SRC_REG[gi]][SRC_LSB[gi]+:LVL_W]),
            .debug_i(gi < NDBG),
            .en_o(dec_en[gi]),
            .level_o(dec_level[gi])
         );
         // registered enable and level toward the arbiter
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               src_en_o[gi] <= 1'b0;
               src_level_o[gi*LVL_W+:LVL_W] <= CODE_OFF;
            end else begin
               src_en_o[gi] <= dec_en[gi];
               src_level_o[gi*LVL_W+:LVL_W] <= dec_level[gi];
            end
         end
         ipl_nest_check u_nest (
            .core_ipl_i(core_ipl_i),
            .level_i(src_level_o[gi*LVL_W+:LVL_W]),
            .accept_o(accept[gi])
         );
         // masking, nesting and fast qualification
         assign src_req_o[gi] = raw_req[gi] && src_en_o[gi];
         assign nest_ok_o[gi] = src_req_o[gi] && accept[gi];
         assign fast_o[gi] = src_req_o[gi]
            && (src_level_o[gi*LVL_W+:LVL_W] == LVL_TWO)
            && (SRC_VEC[gi] == fast_match_0 || SRC_VEC[gi] == fast_match_1);
      end
   endgenerate

   // ----------------------------------------------------------------
   // external request pins
   // ----------------------------------------------------------------
   // three-stage synchronisers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync_a <= 3'h7;
         sync_b <= 3'h7;
      end else begin
         sync_a <= {sync_a[1:0], ext_req_a_i};
         sync_b <= {sync_b[1:0], ext_req_b_i};
      end
   end

   // filtered level changes when second and third stage agree
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_a <= 1'b1;
         pin_b <= 1'b1;
         pin_a_d <= 1'b1;
         pin_b_d <= 1'b1;
      end else begin
         if (sync_a[1] == sync_a[2]) begin
            pin_a <= sync_a[2];
         end
         if (sync_b[1] == sync_b[2]) begin
            pin_b <= sync_b[2];
         end
         pin_a_d <= pin_a;
         pin_b_d <= pin_b;
      end
   end

   assign edge_a = pin_a_d && !pin_a;
   assign edge_b = pin_b_d && !pin_b;

   // request vector, pins forced level-low sensitive in low power
   always_comb begin
      raw_req = src_req_i;
      if (ext_cfg[CFG_EDGE_A] && pwr == ipl_run) begin
         raw_req[SRC_EXT_A] = edge_a;
      end else begin
         raw_req[SRC_EXT_A] = !pin_a;
      end
      if (ext_cfg[CFG_EDGE_B] && pwr == ipl_run) begin
         raw_req[SRC_EXT_B] = edge_b;
      end else begin
         raw_req[SRC_EXT_B] = !pin_b;
      end
   end

   // ----------------------------------------------------------------
   // low power tracking
   // ----------------------------------------------------------------
   // enables captured on entry, only those may wake the core
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pwr <= ipl_run;
         en_snap <= '0;
      end else begin
         case (pwr)
            ipl_run: begin
               if (low_power_i) begin
                  pwr <= ipl_low;
                  en_snap <= src_en_o;
               end
            end
            ipl_low: begin
               if (!low_power_i) begin
                  pwr <= ipl_run;
               end
            end
            default: pwr <= ipl_run;
         endcase
      end
   end

   assign wake_o = (pwr == ipl_low) && |(raw_req & en_snap);

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   property p_rsv_zero;
      wr_go |=> prio[REG_DEBUG][15:6] == '0 && prio[REG_GRP_A][5:4] == '0
         && prio[REG_GRP_B][1:0] == '0;
   endproperty
   a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits set");

   property p_dbg_level;
      ##1 src_en_o[2] |-> src_level_o[5:4] == $past(prio[REG_DEBUG][5:4]);
   endproperty
   a_dbg_level: assert property (p_dbg_level) else $error("debug level wrong");

   property p_dbg_field;
      wr_go && idx == IDX_DEBUG && sel_i[0] |=> ##1
         src_level_o[3:0] == $past(dat_i[3:0], 2) && src_en_o[1] == ($past(dat_i[3:2], 2) != 0);
   endproperty
   a_dbg_field: assert property (p_dbg_field) else $error("debug field misplaced");

   property p_per_level;
      ##1 src_en_o[9] |-> src_level_o[19:18] == $past(prio[REG_GRP_A][15:14]) - 2'h1;
   endproperty
   a_per_level: assert property (p_per_level) else $error("peripheral level wrong");

   property p_reset_off;
      $fell(rst_i) |-> src_en_o == '0 && prio[REG_GRP_B] == '0;
   endproperty
   a_reset_off: assert property (@(posedge clk_i) p_reset_off) else $error("not off after reset");

   property p_grp_a_map;
      wr_go && idx == IDX_GRP_A && sel_i == 4'hF && dat_i[15:14] == 2'h3 && dat_i[1:0] == 2'h0
         |=> ##1 src_en_o[9] && src_level_o[19:18] == 2'h2 && !src_en_o[SRC_EXT_A];
   endproperty
   a_grp_a_map: assert property (p_grp_a_map) else $error("group a mapping");

   property p_grp_b_map;
      wr_go && idx == IDX_GRP_B && sel_i == 4'hF && dat_i[15:14] == 2'h1
         |=> ##1 src_en_o[16] && src_level_o[33:32] == 2'h0;
   endproperty
   a_grp_b_map: assert property (p_grp_b_map) else $error("group b mapping");

   property p_nest;
      nest_ok_o[0] && core_ipl_i == IPL_P23 |-> src_level_o[1:0] == LVL_THREE;
   endproperty
   a_nest: assert property (p_nest) else $error("nesting too low");

   property p_fast;
      |fast_o |-> |(src_en_o & src_req_o);
   endproperty
   a_fast: assert property (p_fast) else $error("fast without request");

   property p_wake;
      wake_o |-> pwr == ipl_low && |en_snap;
   endproperty
   a_wake: assert property (p_wake) else $error("wake from disabled source");

   property p_mask;
      (src_req_o & ~src_en_o) == '0;
   endproperty
   a_mask: assert property (p_mask) else $error("disabled source passed");

   c_write_a: cover property (wr_go && idx == IDX_GRP_A);
   c_fast: cover property (|fast_o);
   c_wake: cover property (wake_o);

endmodule : ipl_regs
`default_nettype wire

//--- verification/ipl_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// core and request sources around the controller
// ------------------------------------------------
module ipl_far_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [ipl_pkg::NSRC-1:0] req_cmd_i,
   input wire logic [ipl_pkg::LVL_W-1:0] ipl_cmd_i,
   input wire logic [1:0] pin_low_cmd_i,
   input wire logic sleep_cmd_i,
   output logic [ipl_pkg::NSRC-1:0] src_req_o,
   output logic ext_req_a_o,
   output logic ext_req_b_o,
   output logic [ipl_pkg::LVL_W-1:0] core_ipl_o,
   output logic low_power_o
);
   import ipl_pkg::*;
   // sources follow commands one edge late; pins pulled up when idle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         src_req_o <= '0;
         ext_req_a_o <= 1'b1;
         ext_req_b_o <= 1'b1;
         core_ipl_o <= IPL_NONE;
         low_power_o <= 1'b0;
      end else begin
         src_req_o <= req_cmd_i;
         ext_req_a_o <= ~pin_low_cmd_i[0];
         ext_req_b_o <= ~pin_low_cmd_i[1];
         core_ipl_o <= ipl_cmd_i;
         low_power_o <= sleep_cmd_i;
      end
   end
endmodule : ipl_far_model
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ipl_pkg::*;
   logic clk_i, rst_i, cyc, stb, we, ack, wake, ext_a, ext_b, low_pwr, sleep_cmd;
   logic [ADR_W-1:0] adr;
   logic [SEL_W-1:0] sel;
   logic [DAT_W-1:0] wdat, rdat, q;
   logic [NSRC-1:0] src_req, en_o, req_o, nest_o, fast_w, req_cmd;
   logic [NSRC*LVL_W-1:0] lvl_o;
   logic [LVL_W-1:0] core_ipl, ipl_cmd;
   logic [1:0] pin_cmd;
   logic [REG_W-1:0] sh [NREG];
   logic [REG_W-1:0] msk [NREG] = '{16'h003F, 16'hFFCF, 16'hFFFC};
   logic [VEC_W-1:0] fm [2];
   int n_mismatch, n_tests, seed, r;
   // register slot and field lsb of each source, in source order
   int reg_of [NSRC] = '{0, 0, 0, 1, 1, 1, 1, 1, 1, 1, 2, 2, 2, 2, 2, 2, 2};
   int lsb_of [NSRC] = '{0, 2, 4, 0, 2, 6, 8, 10, 12, 14, 2, 4, 6, 8, 10, 12, 14};

   // ------------------------------------------------
   // clock, design and far side
   // ------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   ipl_regs dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
      .src_req_i(src_req), .ext_req_a_i(ext_a), .ext_req_b_i(ext_b),
      .core_ipl_i(core_ipl), .low_power_i(low_pwr), .src_en_o(en_o),
      .src_level_o(lvl_o), .src_req_o(req_o), .nest_ok_o(nest_o), .fast_o(fast_w),
      .wake_o(wake));
   ipl_far_model far (.clk_i(clk_i), .rst_i(rst_i), .req_cmd_i(req_cmd),
      .ipl_cmd_i(ipl_cmd), .pin_low_cmd_i(pin_cmd), .sleep_cmd_i(sleep_cmd),
      .src_req_o(src_req), .ext_req_a_o(ext_a), .ext_req_b_o(ext_b),
      .core_ipl_o(core_ipl), .low_power_o(low_pwr));

   // ------------------------------------------------
   // checking and bus tasks
   // ------------------------------------------------
   task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task test_done;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done

   // one classic cycle, held until ack is sampled high
   task wb(input logic w, input logic [IDX_W-1:0] idx, input logic [SEL_W-1:0] s,
      input logic [REG_W-1:0] d);
      int k;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      sel <= s;
      wdat <= {16'h0000, d};
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 20);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (ack !== 1'b1) begin
         n_mismatch++;
         test_done();
      end
   endtask : wb

   // write a priority register and track it, byte lanes and reserved bits
   task wr(input int rg, input logic [SEL_W-1:0] s, input logic [REG_W-1:0] d);
      logic [REG_W-1:0] be;
      be = {{8{s[1]}}, {8{s[0]}}} & msk[rg];
      wb(1'b1, IDX_DEBUG + rg[IDX_W-1:0], s, d);
      sh[rg] = (sh[rg] & ~be) | (d & be);
   endtask : wr

   task rd(input int rg);
      wb(1'b0, IDX_DEBUG + rg[IDX_W-1:0], 4'hF, 16'h0000);
      chk("prio_reg", q, {48'h0, sh[rg]});
   endtask : rd

   // bounded wait on a request bit (w=0) or wake (w=1)
   task wait_sig(input logic w, input int i, input logic v);
      int k;
      k = 0;
      do begin
         @(negedge clk_i);
         k++;
      end while ((w ? wake : req_o[i]) !== v && k < 20);
      chk("wait_sig", w ? wake : req_o[i], v);
      @(posedge clk_i);
   endtask : wait_sig

   // expected outputs from the tracked registers and far-side commands
   task check_all;
      logic [NSRC-1:0] e_en, e_req, e_nest, e_fast;
      logic [NSRC*LVL_W-1:0] e_lvl, lm;
      logic [LVL_W-1:0] c, l;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      for (int i = 0; i < NSRC; i++) begin
         c = sh[reg_of[i]][lsb_of[i] +: 2];
         l = (i < NDBG) ? c : c - 2'h1;
         e_en[i] = (c != 2'h0);
         lm[2*i +: 2] = {2{e_en[i]}};
         e_lvl[2*i +: 2] = e_en[i] ? l : 2'h0;
         e_req[i] = e_en[i] & req_cmd[i] & (i != SRC_EXT_A) & (i != SRC_EXT_B);
         e_nest[i] = e_req[i] & (l >= ipl_cmd);
         e_fast[i] = e_req[i] & (l == 2'h2) & ((fm[0] == 7'h10 + i) | (fm[1] == 7'h10 + i));
      end
      chk("src_en", en_o, e_en);
      chk("src_level", lvl_o & lm, e_lvl);
      chk("src_req", req_o, e_req);
      chk("nest_ok", nest_o, e_nest);
      chk("fast", fast_w, e_fast);
      @(posedge clk_i);
   endtask : check_all

   // ------------------------------------------------
   // main sequence
   // ------------------------------------------------
   initial begin
      seed = 33763;
      n_mismatch = 0;
      n_tests = 0;
      sh = '{default: 16'h0000};
      fm = '{7'h00, 7'h00};
      rst_i = 1'b1;
      {cyc, stb, we, sleep_cmd} = 4'h0;
      {adr, sel, wdat, req_cmd, ipl_cmd, pin_cmd} = '0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      for (r = 0; r < NREG; r++) rd(r);
      check_all();
      $display("test reset done");
      // every code in every field at once
      for (int c = 0; c < 4; c++) begin
         req_cmd <= '1;
         ipl_cmd <= c[1:0];
         for (r = 0; r < NREG; r++) wr(r, 4'hF, REG_W'(16'h5555 * c));
         for (r = 0; r < NREG; r++) rd(r);
         check_all();
      end
      // flash bufs at its top code, external a left off
      wr(1, 4'hF, 16'hC000);
      check_all();
      $display("test codes done");
      // random fields, byte lanes, match vectors and core level
      for (int k = 0; k < 40; k++) begin
         r = $unsigned($random(seed)) % 3;
         wr(r, SEL_W'(1 + $unsigned($random(seed)) % 3), REG_W'($random(seed)));
         fm[k % 2] = VEC_W'(16 + $unsigned($random(seed)) % 17);
         wb(1'b1, (k % 2) ? IDX_FAST1 : IDX_FAST0, 4'h3, {9'h000, fm[k % 2]});
         req_cmd <= NSRC'($random(seed));
         ipl_cmd <= LVL_W'($random(seed));
         rd(r);
         check_all();
      end
      $display("test random done");
      // unmapped index is acked, reads zero, changes nothing
      wb(1'b1, 6'h05, 4'h3, 16'hFFFF);
      wb(1'b0, 6'h05, 4'hF, 16'h0000);
      chk("unmapped", q, 64'h0);
      for (r = 0; r < NREG; r++) rd(r);
      $display("test unmapped done");
      // both pins in level mode
      req_cmd <= '0;
      wr(1, 4'h3, 16'h004A);
      pin_cmd <= 2'b11;
      wait_sig(1'b0, SRC_EXT_A, 1'b1);
      wait_sig(1'b0, SRC_EXT_B, 1'b1);
      chk("ext_levels", lvl_o[9:6], 4'h5);
      pin_cmd <= 2'b00;
      wait_sig(1'b0, SRC_EXT_A, 1'b0);
      wait_sig(1'b0, SRC_EXT_B, 1'b0);
      $display("test pins done");
      // low power with pins set to falling edge
      wb(1'b1, IDX_EXT_CFG, 4'h3, 16'h0003);
      sleep_cmd <= 1'b1;
      repeat (3) @(posedge clk_i);
      wr(1, 4'h3, 16'h014A);
      req_cmd <= 17'h00040;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      chk("wake_late_enable", wake, 1'b0);
      @(posedge clk_i);
      req_cmd <= 17'h00020;
      wait_sig(1'b1, 0, 1'b1);
      req_cmd <= '0;
      pin_cmd <= 2'b01;
      wait_sig(1'b0, SRC_EXT_A, 1'b1);
      repeat (8) @(posedge clk_i);
      @(negedge clk_i);
      chk("ext_a_held", req_o[SRC_EXT_A], 1'b1);
      @(posedge clk_i);
      pin_cmd <= 2'b10;
      sleep_cmd <= 1'b0;
      // back in run mode a falling edge on pin b gives a one-cycle request
      wait_sig(1'b0, SRC_EXT_B, 1'b1);
      @(negedge clk_i);
      chk("ext_b_edge_pulse", req_o[SRC_EXT_B], 1'b0);
      @(posedge clk_i);
      pin_cmd <= 2'b00;
      $display("test low power done");
      // second reset in mid-run clears every field
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      sh = '{default: 16'h0000};
      fm = '{7'h00, 7'h00};
      req_cmd <= '1;
      for (r = 0; r < NREG; r++) rd(r);
      check_all();
      $display("test second reset done");
      test_done();
   end
endmodule : tb
`default_nettype wire
